// *** src/self_program_flash_control.v ***
// self-programming controller for the on-chip program flash
`timescale 1ns/1ps
`default_nettype none
`include "spfc_regs.vh"
// Function
// RULE_01 - enable-only pattern then store within four cycles loads one buffer word
// RULE_02 - buffer clears after page write, on clear bit, and after system reset
// RULE_03 - software loads each buffer word once between clears
// RULE_04 - eeprom write during page loading discards all loaded words
// RULE_05 - page write pattern plus store writes page, ignores data, halts core
// RULE_06 - pointer splits into word-in-page and page parts; erase, write independent
// RULE_07 - load-program reads bytes, so pointer bit zero selects the byte
// RULE_08 - control register: bits 7..5 read zero, bits 4..0 read/write
// RULE_09 - writing clear bit while filling empties buffer and loses data
// RULE_10 - page write bit arms next store; clears on completion or timeout
// RULE_11 - page erase bit arms next store; halts core; clears on completion/timeout
// RULE_12 - enable opens store for four cycles; load ignores pointer lsb
// RULE_13 - enable self-clears after store or timeout, stays set during operations
// RULE_14 - only five low-bit patterns act; any other write has no effect
// RULE_15 - eeprom write busy blocks programming commands and fuse reads
// RULE_16 - software checks eeprom busy clear before writing control register
// RULE_17 - pointer one, fuse read: lock two in bit 1, lock one in bit 0
// RULE_18 - fuse read and enable clear after read or three-cycle/four-cycle timeout
// RULE_19 - pointer zero in read window returns fuse low byte
// RULE_20 - pointer three in read window returns fuse high byte
// RULE_21 - programmed bits read zero, unprogrammed bits read one
// RULE_22 - a running flash write finishes through a system reset
// RULE_23 - page erase pattern plus store erases page, ignores data, halts core
// RULE_24 - erase and write last the timed programming period of 3.7 ms min
// RULE_25 - page geometry widths are design parameters
module self_program_flash_control #(
    // RULE_25 page geometry parameters, then the programming cycle count
    parameter WORD_W = `WORD_W_DEF,
    parameter PAGE_W = `PAGE_W_DEF,
    parameter [16:0] PROG_CYCLES = `PROG_CYCLES_DEF
) (
    // clock and resets
    input wire core_clk_i,
    input wire reset_n_i,
    input wire por_n_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // core instruction side
    input wire store_instr_i,
    input wire load_instr_i,
    input wire [15:0] z_ptr_i,
    input wire [15:0] write_data_pair_i,
    output reg fuse_read_valid_o,
    output reg [7:0] fuse_read_data_o,
    output reg core_halt_o,
    // eeprom status
    input wire eeprom_write_busy_i,
    // fuse and lock state, one means programmed
    input wire [7:0] fuse_low_prog_i,
    input wire [7:0] fuse_high_prog_i,
    input wire lock_bit_one_prog_i,
    input wire lock_bit_two_prog_i,
    // flash array side
    output reg flash_erase_o,
    output reg flash_write_o,
    output reg [PAGE_W-1:0] flash_page_o,
    output reg flash_wr_en_o,
    output reg [WORD_W-1:0] flash_wr_word_o,
    output reg [15:0] flash_wr_data_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_STREAM = 3'b010;
    localparam ST_PROG = 3'b100;
    localparam NWORDS = 1 << WORD_W;
    localparam [WORD_W-1:0] LAST_WORD = {WORD_W{1'b1}};

    function legal_pat;
        input [4:0] pat;
        begin
            legal_pat = (pat == `PAT_CLEAR) || (pat == `PAT_FUSE) || (pat == `PAT_WRITE) ||
                (pat == `PAT_ERASE) || (pat == `PAT_LOAD);
        end
    endfunction

    // reset synchronisers
    reg rst_meta_ff;
    reg rst_sync_ff;
    reg por_meta_ff;
    reg por_sync_ff;

    // system-reset domain state
    reg [4:0] ctrl_ff;
    reg [2:0] win_ff;

    // power-on domain state, survives a system reset so a running write completes
    reg [2:0] state_ff;
    reg [WORD_W-1:0] idx_ff;
    reg issue_ff;
    reg issue_vld_ff;
    reg [WORD_W-1:0] issue_idx_ff;
    reg [NWORDS-1:0] vld_ff;
    reg rst_pend_ff;

    wire [15:0] ram_q;
    wire tmr_done;
    reg [7:0] nxt_fuse_byte;

    always @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always @(posedge core_clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            por_meta_ff <= 1'b0;
            por_sync_ff <= 1'b0;
        end
        else
        begin
            por_meta_ff <= 1'b1;
            por_sync_ff <= por_meta_ff;
        end
    end

    // bus decode: a write lands on the edge where the master sees ack
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire wb_take = wb_req & wb_ack_o;
    wire spc_hit = (wb_adr_i[7:2] == `SPC_IDX);
    wire stat_hit = (wb_adr_i[7:2] == `STAT_IDX);
    wire [4:0] new_pat = wb_dat_i[4:0];
    wire eng_idle = (state_ff == ST_IDLE);
    // RULE_15 eeprom blocks commands
    wire ctrl_blocked = eeprom_write_busy_i | ~eng_idle;
    // RULE_14 only legal patterns
    wire ctrl_take = wb_take & wb_we_i & wb_sel_i[0] & spc_hit & legal_pat(new_pat) &
        ~ctrl_blocked;

    // RULE_12 store window open
    wire store_ok = store_instr_i & ctrl_ff[`BIT_ENABLE] & (win_ff != 3'h0) & eng_idle &
        ~eeprom_write_busy_i;
    // RULE_10 armed page write
    wire op_write = store_ok & ctrl_ff[`BIT_PG_WRITE];
    // RULE_11 armed page erase
    wire op_erase = store_ok & ctrl_ff[`BIT_PG_ERASE];
    // RULE_01 plain word load
    wire buf_load = store_ok & (ctrl_ff == `PAT_LOAD);
    // RULE_12 lsb of pointer ignored
    wire [WORD_W-1:0] z_word = z_ptr_i[WORD_W:1];
    // RULE_06 page part above word part
    wire [PAGE_W-1:0] z_page = z_ptr_i[WORD_W+PAGE_W:WORD_W+1];
    // RULE_18 three-cycle load window
    wire load_ok = load_instr_i & ctrl_ff[`BIT_FUSE_RD] & ctrl_ff[`BIT_ENABLE] &
        (win_ff >= `LOAD_LAST) & ~eeprom_write_busy_i;
    wire op_done = (state_ff == ST_PROG) & tmr_done;
    wire tmr_start = op_erase | ((state_ff == ST_STREAM) & (idx_ff == LAST_WORD));
    // RULE_03 a second load to a filled word is dropped
    wire ram_we = buf_load & ~vld_ff[z_word];
    // RULE_09 clear pattern empties buffer
    wire clr_by_sw = ctrl_take & (new_pat == `PAT_CLEAR);
    // RULE_04 eeprom write kills partial load
    wire clr_by_ee = eeprom_write_busy_i & (|vld_ff);
    // RULE_02 clear after reset or page write
    wire clr_by_hw = (eng_idle & (rst_pend_ff | ~rst_sync_ff)) | (op_done & flash_write_o);

    always @(posedge core_clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            ctrl_ff <= `CTRL_RESET;
            win_ff <= 3'h0;
        end
        else if (ctrl_take)
        begin
            ctrl_ff <= new_pat;
            win_ff <= `STORE_WIN;
        end
        else if (op_done)
        begin
            ctrl_ff <= `CTRL_RESET;
            win_ff <= 3'h0;
        end
        else if (!eng_idle)
        begin
            // RULE_13 enable held during operation
            ctrl_ff <= ctrl_ff;
        end
        else if (op_write | op_erase)
        begin
            win_ff <= 3'h0;
        end
        else if (store_ok | load_ok)
        begin
            // RULE_13 clear after store
            ctrl_ff <= `CTRL_RESET;
            win_ff <= 3'h0;
        end
        else if (ctrl_ff[`BIT_FUSE_RD] & (win_ff == `LOAD_LAST))
        begin
            // RULE_18 three cycles without load
            ctrl_ff <= `CTRL_RESET;
            win_ff <= 3'h0;
        end
        else if (win_ff == 3'h1)
        begin
            // RULE_13 four cycles without store
            ctrl_ff <= `CTRL_RESET;
            win_ff <= 3'h0;
        end
        else if (win_ff != 3'h0)
        begin
            win_ff <= win_ff - 3'h1;
        end
    end

    always @*
    begin
        nxt_fuse_byte = 8'hff;
        // RULE_07 full pointer including bit zero
        case (z_ptr_i)
            `Z_FUSE_LOW:
            begin
                // RULE_19 fuse low byte
                // RULE_21 programmed reads zero
                nxt_fuse_byte = ~fuse_low_prog_i;
            end
            `Z_LOCK:
            begin
                // RULE_17 lock bits two and one
                nxt_fuse_byte = {6'h3f, ~lock_bit_two_prog_i, ~lock_bit_one_prog_i};
            end
            `Z_FUSE_HIGH:
            begin
                // RULE_20 fuse high byte
                nxt_fuse_byte = ~fuse_high_prog_i;
            end
            default:
            begin
                nxt_fuse_byte = 8'hff;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            fuse_read_valid_o <= 1'b0;
            fuse_read_data_o <= 8'h00;
        end
        else
        begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o & spc_hit)
            begin
                // RULE_08 reserved bits read zero
                wb_dat_o <= {27'h0, ctrl_ff};
            end
            else if (wb_req & ~wb_ack_o & stat_hit)
            begin
                wb_dat_o <= {27'h0, eeprom_write_busy_i, rst_pend_ff, flash_erase_o,
                    flash_write_o, core_halt_o};
            end
            else if (wb_req & ~wb_ack_o)
            begin
                wb_dat_o <= 32'h0;
            end
            fuse_read_valid_o <= load_ok;
            if (load_ok)
            begin
                fuse_read_data_o <= nxt_fuse_byte;
            end
        end
    end

    // RULE_22 engine runs on power-on reset only
    always @(posedge core_clk_i or negedge por_sync_ff)
    begin
        if (!por_sync_ff)
        begin
            state_ff <= ST_IDLE;
            idx_ff <= {WORD_W{1'b0}};
            issue_ff <= 1'b0;
            issue_vld_ff <= 1'b0;
            issue_idx_ff <= {WORD_W{1'b0}};
            vld_ff <= {NWORDS{1'b0}};
            rst_pend_ff <= 1'b0;
            core_halt_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_write_o <= 1'b0;
            flash_page_o <= {PAGE_W{1'b0}};
            flash_wr_en_o <= 1'b0;
            flash_wr_word_o <= {WORD_W{1'b0}};
            flash_wr_data_o <= 16'h0;
        end
        else
        begin
            // buffer words stream out two cycles after their read is issued
            issue_ff <= (state_ff == ST_STREAM);
            issue_idx_ff <= idx_ff;
            issue_vld_ff <= vld_ff[idx_ff];
            flash_wr_en_o <= issue_ff;
            flash_wr_word_o <= issue_idx_ff;
            flash_wr_data_o <= issue_vld_ff ? ram_q : 16'hffff;
            if (!rst_sync_ff & !eng_idle)
            begin
                rst_pend_ff <= 1'b1;
            end
            else if (eng_idle)
            begin
                rst_pend_ff <= 1'b0;
            end
            if (clr_by_sw | clr_by_ee | clr_by_hw)
            begin
                vld_ff <= {NWORDS{1'b0}};
            end
            else if (ram_we)
            begin
                vld_ff[z_word] <= 1'b1;
            end
            case (state_ff)
                ST_IDLE:
                begin
                    if (op_erase)
                    begin
                        // RULE_23 erase halts core
                        state_ff <= ST_PROG;
                        flash_erase_o <= 1'b1;
                        core_halt_o <= 1'b1;
                        flash_page_o <= z_page;
                    end
                    else if (op_write)
                    begin
                        // RULE_05 write halts core
                        state_ff <= ST_STREAM;
                        flash_write_o <= 1'b1;
                        core_halt_o <= 1'b1;
                        flash_page_o <= z_page;
                        idx_ff <= {WORD_W{1'b0}};
                    end
                end
                ST_STREAM:
                begin
                    idx_ff <= idx_ff + {{(WORD_W-1){1'b0}}, 1'b1};
                    if (idx_ff == LAST_WORD)
                    begin
                        state_ff <= ST_PROG;
                    end
                end
                ST_PROG:
                begin
                    // RULE_24 timed programming period
                    if (tmr_done)
                    begin
                        state_ff <= ST_IDLE;
                        flash_erase_o <= 1'b0;
                        flash_write_o <= 1'b0;
                        core_halt_o <= 1'b0;
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    page_buffer_ram #(
        .WORD_W(WORD_W)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .wr_en_i(ram_we),
        .wr_addr_i(z_word),
        .wr_data_i(write_data_pair_i),
        .rd_addr_i(idx_ff),
        .rd_data_o(ram_q)
    );

    flash_op_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_tmr (
        .core_clk_i(core_clk_i),
        .por_n_i(por_sync_ff),
        .start_i(tmr_start),
        .done_o(tmr_done)
    );
endmodule
`default_nettype wire

// *** src/spfc_regs.vh ***
// offsets, field positions, patterns and timing counts of the self-program flash control
`ifndef SPFC_REGS_VH
`define SPFC_REGS_VH

// word index of each register; byte address is four times the index
`define SPC_IDX 6'h00
`define STAT_IDX 6'h01

// store_program_control fields
`define BIT_BUF_CLR 4
`define BIT_FUSE_RD 3
`define BIT_PG_WRITE 2
`define BIT_PG_ERASE 1
`define BIT_ENABLE 0
`define CTRL_RESET 5'h00

// the only accepted low-five-bit patterns
`define PAT_CLEAR 5'h11
`define PAT_FUSE 5'h09
`define PAT_WRITE 5'h05
`define PAT_ERASE 5'h03
`define PAT_LOAD 5'h01

// command windows in clock cycles after the register write
`define STORE_WIN 3'h4
`define LOAD_LAST 3'h2

// fuse and lock addresses in the pointer
`define Z_FUSE_LOW 16'h0000
`define Z_LOCK 16'h0001
`define Z_FUSE_HIGH 16'h0003

// page geometry defaults
`define WORD_W_DEF 4
`define PAGE_W_DEF 5

// flash programming time
`define CLK_PERIOD_NS 50
`define PROG_MIN_NS 3700000
`define PROG_MAX_NS 4500000
// minimum time over the clock period, rounded up, sized to the timer width
`define PROG_CYCLES_DEF 17'h12110
`define PROG_CNT_W 17

`endif

// *** src/page_buffer_ram.v ***
// temporary page buffer storage, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module page_buffer_ram #(
    parameter WORD_W = 4
) (
    // clock
    input wire core_clk_i,
    // write port
    input wire wr_en_i,
    input wire [WORD_W-1:0] wr_addr_i,
    input wire [15:0] wr_data_i,
    // read port
    input wire [WORD_W-1:0] rd_addr_i,
    output reg [15:0] rd_data_o
);
    reg [15:0] mem [0:(1<<WORD_W)-1];

    // no reset: validity is tracked per word outside, so contents never need clearing
    always @(posedge core_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// *** src/flash_op_timer.v ***
// programming time counter for erase and write operations
`timescale 1ns/1ps
`default_nettype none
module flash_op_timer #(
    parameter [16:0] CYCLES = 17'h1
) (
    // clock and reset
    input wire core_clk_i,
    input wire por_n_i,
    // control
    input wire start_i,
    output wire done_o
);
    reg busy_ff;
    reg [16:0] cnt_ff;

    assign done_o = busy_ff & (cnt_ff == 17'h0);

    always @(posedge core_clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 17'h0;
        end
        else if (start_i)
        begin
            busy_ff <= 1'b1;
            cnt_ff <= CYCLES - 17'h1;
        end
        else if (done_o)
        begin
            busy_ff <= 1'b0;
        end
        else if (busy_ff)
        begin
            cnt_ff <= cnt_ff - 17'h1;
        end
    end
endmodule
`default_nettype wire

// *** test/spfc_sva.sv ***
// port assertions for the self-program flash control
`timescale 1ns/1ps
`default_nettype none
module spfc_sva #(
    parameter [16:0] PROG_CYCLES = 17'h1
) (
    // clock and resets
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // core and flash side
    input wire logic store_instr_i,
    input wire logic load_instr_i,
    input wire logic eeprom_write_busy_i,
    input wire logic fuse_read_valid_o,
    input wire logic core_halt_o,
    input wire logic flash_erase_o,
    input wire logic flash_write_o,
    input wire logic flash_wr_en_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // only power-on reset may cut an erase short, so the count ignores system reset
    logic [16:0] ers_cnt_ff;
    always_ff @(posedge core_clk_i or negedge por_n_i)
    begin
        if (!por_n_i)
            ers_cnt_ff <= 17'h0;
        else
            ers_cnt_ff <= flash_erase_o ? ers_cnt_ff + 17'h1 : 17'h0;
    end
    ack_follows_req_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
        |=> wb_ack_o) else $error("bus request not acknowledged");
    ctrl_rsvd_zero_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00)
        |-> wb_dat_o[31:5] == 27'h0) else $error("reserved control bits not zero");
    halt_cause_a: assert property ($rose(core_halt_o)
        |-> $past(store_instr_i) && !$past(eeprom_write_busy_i)) else $error("halt without store");
    erase_halts_a: assert property (flash_erase_o |-> core_halt_o)
        else $error("erase without halt");
    write_halts_a: assert property (flash_write_o |-> core_halt_o)
        else $error("write without halt");
    wren_in_write_a: assert property (flash_wr_en_o |-> flash_write_o)
        else $error("word streamed outside write");
    fuse_cause_a: assert property (fuse_read_valid_o
        |-> $past(load_instr_i) && !$past(eeprom_write_busy_i))
        else $error("fuse read without load");
    fuse_pulse_a: assert property (fuse_read_valid_o |=> !fuse_read_valid_o)
        else $error("fuse read repeated");
    erase_time_a: assert property (disable iff (!por_n_i)
        $fell(flash_erase_o) |-> ers_cnt_ff == PROG_CYCLES) else $error("erase length wrong");
endmodule
bind self_program_flash_control spfc_sva #(.PROG_CYCLES(PROG_CYCLES)) sva_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .por_n_i(por_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .store_instr_i(store_instr_i),
    .load_instr_i(load_instr_i), .eeprom_write_busy_i(eeprom_write_busy_i),
    .fuse_read_valid_o(fuse_read_valid_o), .core_halt_o(core_halt_o),
    .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
    .flash_wr_en_o(flash_wr_en_o)
);
`default_nettype wire

// *** test/core_model.sv ***
// behavioural core issuing store and load-program instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic core_clk_i,
    output logic store_instr_o,
    output logic load_instr_o,
    output logic [15:0] z_ptr_o,
    output logic [15:0] wr_pair_o
);
    initial
    begin
        store_instr_o = 1'b0;
        load_instr_o = 1'b0;
        z_ptr_o = 16'h5a5a;
        wr_pair_o = 16'ha5a5;
    end
    task automatic issue(input logic l, input int dly, input logic [15:0] z, input logic [15:0] d);
        repeat (dly) @(posedge core_clk_i);
        store_instr_o <= !l;
        load_instr_o <= l;
        z_ptr_o <= z;
        wr_pair_o <= d;
        @(posedge core_clk_i);
        store_instr_o <= 1'b0;
        load_instr_o <= 1'b0;
        // pointer and data are not held after the strobe
        z_ptr_o <= ~z;
        wr_pair_o <= ~d;
    endtask
endmodule
`default_nettype wire

// *** test/self_program_flash_control_tb.sv ***
// randomised bench for the self-program flash control
`timescale 1ns/1ps
`default_nettype none
`include "spfc_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module self_program_flash_control_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic busy = 1'b0;
    logic l1 = 1'b0;
    logic l2 = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [7:0] flo = 8'h0;
    logic [7:0] fhi = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q;
    logic ack, st, ld, fval, halt, ers, wrt, wren;
    logic [15:0] z, pair, wdata;
    logic [7:0] fdat;
    logic [4:0] page, p;
    logic [3:0] wword;
    logic [15:0] exp_buf [16];
    logic [15:0] got_buf [16];
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'h92e5;
    self_program_flash_control #(.PROG_CYCLES(17'h14)) DUT (
        .core_clk_i(clk), .reset_n_i(rst_n), .por_n_i(por_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .store_instr_i(st), .load_instr_i(ld), .z_ptr_i(z),
        .write_data_pair_i(pair), .fuse_read_valid_o(fval), .fuse_read_data_o(fdat),
        .core_halt_o(halt), .eeprom_write_busy_i(busy), .fuse_low_prog_i(flo),
        .fuse_high_prog_i(fhi), .lock_bit_one_prog_i(l1), .lock_bit_two_prog_i(l2),
        .flash_erase_o(ers), .flash_write_o(wrt), .flash_page_o(page), .flash_wr_en_o(wren),
        .flash_wr_word_o(wword), .flash_wr_data_o(wdata));
    core_model core (.core_clk_i(clk), .store_instr_o(st), .load_instr_o(ld),
        .z_ptr_o(z), .wr_pair_o(pair));
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (wren === 1'b1)
            got_buf[wword] <= wdata;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end
    function automatic logic [7:0] fexp(input logic [15:0] zz);
        case (zz)
            `Z_FUSE_LOW: fexp = ~flo;
            `Z_LOCK: fexp = {6'h3f, ~l2, ~l1};
            `Z_FUSE_HIGH: fexp = ~fhi;
            default: fexp = 8'hff;
        endcase
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // returns one edge after the strobe so halt and valid have landed
    task automatic cmd(input logic [4:0] pat, input logic l, input int dly,
        input logic [15:0] zz, input logic [15:0] d);
        wb(8'h00, 1'b1, {27'h0, pat});
        core.issue(l, dly, zz, d);
        @(posedge clk);
    endtask
    task automatic load_word(input logic [4:0] pg, input logic [3:0] w, input int dly);
        logic [15:0] d;
        d = 16'($random(seed));
        exp_buf[w] = d;
        cmd(`PAT_LOAD, 1'b0, dly, {6'h0, pg, w, 1'($random(seed))}, d);
    endtask
    task automatic pg_write(input logic [4:0] pg);
        got_buf = '{default: 16'h0};
        cmd(`PAT_WRITE, 1'b0, 0, {6'h0, pg, 5'h0}, 16'($random(seed)));
        `CHK(halt, 1'b1)
        `CHK(wrt, 1'b1)
        `CHK(page, pg)
        while (halt !== 1'b0)
            @(posedge clk);
        for (int i = 0; i < 16; i++)
            `CHK(got_buf[i], exp_buf[i])
        exp_buf = '{default: 16'hffff};
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q, 32'h0)
    endtask
    initial
    begin
        exp_buf = '{default: 16'hffff};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        for (int i = 0; i < 6; i++)
        begin
            wb(8'h00, 1'b1, i == 0 ? 32'hff : 32'($random(seed)) & 32'hfe);
            wb(8'h00, 1'b0, 32'h0);
            `CHK(q, 32'h0)
        end
        wb(8'h00, 1'b1, 32'h1);
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q, 32'h1)
        repeat (4) @(posedge clk);
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        tdone("registers");
        p = 5'($random(seed));
        // words 5 and 11 stay unloaded and must stream as erased
        // every remaining word loaded once
        for (int w = 0; w < 16; w++)
            if (w != 5 && w != 11)
                load_word(p, 4'(w), w % 4);
        pg_write(p);
        pg_write(p);
        load_word(p, 4'h0, 0);
        load_word(p, 4'h1, 3);
        cmd(`PAT_CLEAR, 1'b0, 0, 16'h0, 16'h0);
        exp_buf = '{default: 16'hffff};
        pg_write(p);
        tdone("page buffer");
        load_word(p, 4'h2, 1);
        busy <= 1'b1;
        @(posedge clk);
        busy <= 1'b0;
        exp_buf = '{default: 16'hffff};
        pg_write(p);
        busy <= 1'b1;
        cmd(`PAT_ERASE, 1'b0, 0, 16'h0, 16'h0);
        `CHK(halt, 1'b0)
        cmd(`PAT_FUSE, 1'b1, 0, 16'h0, 16'h0);
        `CHK(fval, 1'b0)
        busy <= 1'b0;
        cmd(`PAT_ERASE, 1'b0, 4, 16'h0, 16'h0);
        `CHK(halt, 1'b0)
        cmd(`PAT_WRITE, 1'b0, 4, 16'h0, 16'h0);
        `CHK(halt, 1'b0)
        tdone("blocking");
        load_word(p, 4'h7, 2);
        cmd(`PAT_ERASE, 1'b0, 3, {6'h0, ~p, 5'h1f}, 16'hffff);
        `CHK(halt, 1'b1)
        `CHK(ers, 1'b1)
        `CHK(page, ~p)
        wb(8'h00, 1'b0, 32'h0);
        `CHK(q, 32'h3)
        wb(8'h04, 1'b0, 32'h0);
        `CHK(q, 32'h5)
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(ers, 1'b1)
        wb(8'h04, 1'b0, 32'h0);
        `CHK(q, 32'hd)
        while (halt !== 1'b0)
            @(posedge clk);
        exp_buf = '{default: 16'hffff};
        pg_write(p);
        tdone("erase");
        for (int k = 0; k < 6; k++)
        begin
            flo <= 8'($random(seed));
            fhi <= 8'($random(seed));
            {l2, l1} <= 2'($random(seed));
            cmd(`PAT_FUSE, 1'b1, k == 5 ? 3 : k % 3, 16'(k % 4), 16'h0);
            if (k == 5)
                `CHK(fval, 1'b0)
            else
            begin
                `CHK(fval, 1'b1)
                `CHK(fdat, fexp(16'(k % 4)))
            end
        end
        tdone("fuse read");
        results();
    end
endmodule
`default_nettype wire
